/* File: verilog/gain_ctrl_pkg.sv */
// Constants for the two-register write-only control slave
package gain_ctrl_pkg;
    localparam logic [6:0] DEV_ADDR       = 7'h6f;
    localparam int         SEL_BIT        = 7;
    localparam int         ENABLE_BIT     = 0;
    localparam int         MUTE_BIT       = 1;
    localparam int         TEST_BIT       = 4;
    localparam int         GAIN_W         = 6;
    localparam logic [7:0] MODE_RST       = 8'h00;
    localparam logic [7:0] GAIN_RST       = 8'h80;
    localparam logic [5:0] GAIN_MUTE_CODE = 6'h00;
    localparam logic [3:0] ACK_SLOT       = 4'h8;
    localparam logic [3:0] ACK_DONE       = 4'h9;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_ADDR = 4'b0010,
        ST_DATA = 4'b0100,
        ST_ACK  = 4'b1000
    } slave_state_t;
endpackage

/* File: verilog/gain_mode_slave.sv */
// Write-only serial control slave holding mode and gain registers
`timescale 1ns/10ps

module gain_mode_slave (
    input  wire logic                         mclk,
    input  wire logic                         rst_b,
    input  wire logic                         clk_en,
    input  wire logic                         scl,
    input  wire logic                         sda_in,
    output logic                              sda_out,
    output logic                              sda_oe,
    output logic                              amp_enable,
    output logic                              mute,
    output logic                              factory_test_select,
    output logic [gain_ctrl_pkg::GAIN_W-1:0]  gain_code,
    output logic [gain_ctrl_pkg::GAIN_W-1:0]  gain_out
);
    import gain_ctrl_pkg::*;

    // Bus edge detection, inputs already synchronous
    // Reset to idle high so no false STOP follows reset
    logic         scl_reg, scl_next;
    logic         sda_reg, sda_next;
    logic         scl_rise, scl_fall, start_det, stop_det;

    always_comb begin
        scl_next = scl;
        sda_next = sda_in;
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            scl_reg <= 1'b1;
            sda_reg <= 1'b1;
        end else if (clk_en) begin
            scl_reg <= scl_next;
            sda_reg <= sda_next;
        end
    end

    assign scl_rise  = scl & ~scl_reg;
    assign scl_fall  = ~scl & scl_reg;
    assign start_det = scl & scl_reg & sda_reg & ~sda_in;
    assign stop_det  = scl & scl_reg & ~sda_reg & sda_in;

    // Protocol engine
    // Count cleared only at START or ack end; stray bytes never line up
    slave_state_t state_reg, state_next;
    logic [3:0]   bit_cnt_reg, bit_cnt_next;
    logic [7:0]   shift_reg, shift_next;
    logic         addr_phase_reg, addr_phase_next;
    logic         oe_reg, oe_next;
    logic [7:0]   mode_reg, mode_next;
    logic [7:0]   gain_reg, gain_next;

    function automatic logic addr_hit(input logic [7:0] b);
        addr_hit = (b[7:1] == DEV_ADDR) && !b[0];
    endfunction

    always_comb begin
        state_next      = state_reg;
        bit_cnt_next    = bit_cnt_reg;
        shift_next      = shift_reg;
        addr_phase_next = addr_phase_reg;
        oe_next         = oe_reg;
        mode_next       = mode_reg;
        gain_next       = gain_reg;
        if (start_det) begin
            state_next      = ST_ADDR;
            bit_cnt_next    = 4'h0;
            addr_phase_next = 1'b1;
            oe_next         = 1'b0;
        end else if (stop_det) begin
            state_next = ST_IDLE;
            oe_next    = 1'b0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    oe_next = 1'b0;
                end
                ST_ADDR, ST_DATA: begin
                    if (scl_rise) begin
                        shift_next   = {shift_reg[6:0], sda_in};
                        bit_cnt_next = bit_cnt_reg + 4'h1;
                    end
                    if (scl_fall && bit_cnt_reg == ACK_SLOT) begin
                        if (state_reg == ST_ADDR) begin
                            if (addr_hit(shift_reg)) begin
                                oe_next    = 1'b1;
                                state_next = ST_ACK;
                            end else begin
                                state_next = ST_IDLE;
                            end
                        end else begin
                            oe_next    = 1'b1;
                            state_next = ST_ACK;
                            // Reserved bits are stored but drive nothing
                            if (shift_reg[SEL_BIT])
                                gain_next = shift_reg;
                            else
                                mode_next = shift_reg;
                        end
                    end
                end
                ST_ACK: begin
                    // Hold ack through the ninth clock low-high-low
                    if (scl_rise)
                        bit_cnt_next = ACK_DONE;
                    if (scl_fall && bit_cnt_reg == ACK_DONE) begin
                        oe_next         = 1'b0;
                        bit_cnt_next    = 4'h0;
                        addr_phase_next = 1'b0;
                        state_next      = ST_DATA;
                    end
                end
                default: begin
                    state_next = ST_IDLE;
                    oe_next    = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            state_reg      <= ST_IDLE;
            bit_cnt_reg    <= 4'h0;
            shift_reg      <= 8'h00;
            addr_phase_reg <= 1'b0;
            oe_reg         <= 1'b0;
            mode_reg       <= MODE_RST;
            gain_reg       <= GAIN_RST;
        end else if (clk_en) begin
            state_reg      <= state_next;
            bit_cnt_reg    <= bit_cnt_next;
            shift_reg      <= shift_next;
            addr_phase_reg <= addr_phase_next;
            oe_reg         <= oe_next;
            mode_reg       <= mode_next;
            gain_reg       <= gain_next;
        end
    end

    // Registered outputs, loaded from the next values so they match the registers; gain_out lags them by one cycle
    logic [5:0] gout_next;
    always_comb begin
        gout_next = mode_reg[MUTE_BIT] ? GAIN_MUTE_CODE
                                       : gain_reg[GAIN_W-1:0];
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            sda_out             <= 1'b0;
            sda_oe              <= 1'b0;
            amp_enable          <= 1'b0;
            mute                <= 1'b0;
            factory_test_select <= 1'b0;
            gain_code           <= 6'h00;
            gain_out            <= 6'h00;
        end else if (clk_en) begin
            sda_out             <= 1'b0;
            sda_oe              <= oe_next;
            amp_enable          <= mode_next[ENABLE_BIT];
            mute                <= mode_next[MUTE_BIT];
            factory_test_select <= mode_next[TEST_BIT];
            gain_code           <= gain_next[GAIN_W-1:0];
            gain_out            <= gout_next;
        end
    end

    // Bus-side checks
    property p_no_read_ack;
        @(posedge mclk) disable iff (!rst_b)
        (clk_en && state_reg == ST_ADDR && scl_fall && bit_cnt_reg == ACK_SLOT
         && shift_reg[0]) |=> !sda_oe;
    endproperty
    a_no_read_ack: assert property (p_no_read_ack)
        else $error("read address acknowledged");
    property p_addr_ack;
        @(posedge mclk) disable iff (!rst_b)
        (clk_en && !start_det && !stop_det && state_reg == ST_ADDR && scl_fall
         && bit_cnt_reg == ACK_SLOT && addr_hit(shift_reg)) |=> sda_oe;
    endproperty
    a_addr_ack: assert property (p_addr_ack)
        else $error("matching address not acknowledged");
    property p_mute_gain;
        @(posedge mclk) disable iff (!rst_b)
        (clk_en && mode_reg[MUTE_BIT]) |=> (gain_out == GAIN_MUTE_CODE);
    endproperty
    a_mute_gain: assert property (p_mute_gain)
        else $error("mute did not force gain");
    property p_gain_pass;
        @(posedge mclk) disable iff (!rst_b)
        (clk_en && !mode_reg[MUTE_BIT]) |=> (gain_out == $past(gain_reg[5:0]));
    endproperty
    a_gain_pass: assert property (p_gain_pass)
        else $error("gain code altered");
    property p_reset_clear;
        @(posedge mclk) !rst_b |=> (!amp_enable && gain_code == 6'h00);
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("reset did not clear");
    property p_idle_quiet;
        @(posedge mclk) disable iff (!rst_b)
        (state_reg == ST_IDLE) |=> !sda_oe;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet)
        else $error("drove line while idle");
    property p_mode_write;
        @(posedge mclk) disable iff (!rst_b)
        (clk_en && !start_det && !stop_det && state_reg == ST_DATA && scl_fall
         && bit_cnt_reg == ACK_SLOT && !shift_reg[7])
        |=> (amp_enable == $past(shift_reg[0]) && sda_oe);
    endproperty
    a_mode_write: assert property (p_mode_write)
        else $error("mode write failed");
    property p_gain_write;
        @(posedge mclk) disable iff (!rst_b)
        (clk_en && !start_det && !stop_det && state_reg == ST_DATA && scl_fall
         && bit_cnt_reg == ACK_SLOT && shift_reg[7])
        |=> (gain_code == $past(shift_reg[5:0]) && sda_oe);
    endproperty
    a_gain_write: assert property (p_gain_write)
        else $error("gain write failed");
    property p_data_ack;
        @(posedge mclk) disable iff (!rst_b)
        (clk_en && !start_det && !stop_det && state_reg == ST_DATA && scl_fall
         && bit_cnt_reg == ACK_SLOT) |=> sda_oe;
    endproperty
    a_data_ack: assert property (p_data_ack)
        else $error("data byte not acknowledged");
    property p_ack_release;
        @(posedge mclk) disable iff (!rst_b)
        (clk_en && !start_det && !stop_det && state_reg == ST_ACK && scl_fall
         && bit_cnt_reg == ACK_DONE)
        |=> (!sda_oe && state_reg == ST_DATA);
    endproperty
    a_ack_release: assert property (p_ack_release)
        else $error("ack not released for next byte");
    property p_stop_idle;
        @(posedge mclk) disable iff (!rst_b)
        (clk_en && stop_det) |=> (state_reg == ST_IDLE && !sda_oe);
    endproperty
    a_stop_idle: assert property (p_stop_idle)
        else $error("stop did not return to idle");

    // Register-side checks
    property p_enable_track;
        @(posedge mclk) disable iff (!rst_b)
        clk_en |=> (amp_enable == mode_reg[ENABLE_BIT]);
    endproperty
    a_enable_track: assert property (p_enable_track)
        else $error("enable output differs from mode bit");
    property p_mute_track;
        @(posedge mclk) disable iff (!rst_b)
        clk_en |=> (mute == mode_reg[MUTE_BIT]);
    endproperty
    a_mute_track: assert property (p_mute_track)
        else $error("mute output differs from mode bit");
    property p_test_reset;
        @(posedge mclk) !rst_b |=> !factory_test_select;
    endproperty
    a_test_reset: assert property (p_test_reset)
        else $error("test select not cleared by reset");
    property p_code_track;
        @(posedge mclk) disable iff (!rst_b)
        clk_en |=> (gain_code == gain_reg[GAIN_W-1:0]);
    endproperty
    a_code_track: assert property (p_code_track)
        else $error("gain code output differs from register");
    property p_reserved_quiet;
        @(posedge mclk) disable iff (!rst_b)
        (clk_en && mode_next[1:0] == mode_reg[1:0]
         && mode_next[TEST_BIT] == mode_reg[TEST_BIT])
        |=> ($stable(amp_enable) && $stable(mute)
             && $stable(factory_test_select));
    endproperty
    a_reserved_quiet: assert property (p_reserved_quiet)
        else $error("reserved bit changed behaviour");
    property p_reset_quiet;
        @(posedge mclk) !rst_b |=> (state_reg == ST_IDLE && !sda_oe && !mute);
    endproperty
    a_reset_quiet: assert property (p_reset_quiet)
        else $error("bus not ignored during reset");

    // Main scenarios
    c_ack: cover property (@(posedge mclk) state_reg == ST_ACK);
    c_data: cover property (@(posedge mclk) state_reg == ST_DATA && scl_fall);
    c_stop: cover property (@(posedge mclk) stop_det && state_reg == ST_DATA);
    c_refused: cover property (@(posedge mclk) state_reg == ST_ADDR
        && scl_fall && bit_cnt_reg == ACK_SLOT && !addr_hit(shift_reg));
    c_mute_hold: cover property (@(posedge mclk) mute && gain_code != 6'h00);
endmodule // gain_mode_slave

/* File: test/bus_master_model.sv */
// Behavioural bus master driving serial clock and open-drain data
`timescale 1ns/10ps
module bus_master_model (
    input  wire logic mclk,
    input  wire logic sda_line,
    output logic      scl,
    output logic      sda_low
);
    int phase = 2;
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic hold(input int n);
        repeat (n) @(negedge mclk);
    endtask
    // Works from idle or from after an ack, so repeated start is fine
    task automatic start_cond();
        sda_low = 1'b0;
        hold(2);
        scl = 1'b1;
        hold(phase);
        sda_low = 1'b1;
        hold(3);
        scl = 1'b0;
        hold(2);
    endtask
    task automatic put_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            sda_low = ~b[i];
            hold(2);
            scl = 1'b1;
            hold(phase);
            scl = 1'b0;
            hold(1);
        end
        sda_low = 1'b0;
        hold(2);
        scl = 1'b1;
        hold(2);
        ack = ~sda_line;
        scl = 1'b0;
        hold(3);
    endtask
    task automatic stop_cond();
        sda_low = 1'b1;
        hold(2);
        scl = 1'b1;
        hold(phase);
        sda_low = 1'b0;
        hold(3);
    endtask
endmodule // bus_master_model

/* File: test/tb_top.sv */
// Self-checking bench for the write-only gain and mode control slave
`timescale 1ns/10ps
module tb_top;
    import gain_ctrl_pkg::*;
    logic       mclk, rst_b, clk_en, scl, sda_low, sda_line, sda_out;
    logic       sda_oe, amp_enable, mute, factory_test_select, ack;
    logic [5:0] gain_code, gain_out, vol_e;
    logic [6:0] mode_e;
    int         fails, comparisons, seed_ret;
    // Pull-up on the data wire; either party may pull it low
    assign sda_line = !(sda_low || (sda_oe && !sda_out));
    gain_mode_slave i_dut (.mclk(mclk), .rst_b(rst_b), .clk_en(clk_en),
        .scl(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
        .amp_enable(amp_enable), .mute(mute), .gain_code(gain_code),
        .factory_test_select(factory_test_select), .gain_out(gain_out));
    bus_master_model i_master (.mclk(mclk), .sda_line(sda_line),
        .scl(scl), .sda_low(sda_low));
    task automatic chk(input string n, input logic [7:0] e, g);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    // Test bit low, middle gain codes avoided, reserved bits random
    function automatic logic [7:0] rand_byte();
        logic [7:0] r;
        int         c;
        r = 8'($urandom);
        c = $urandom % 36;
        if (r[7]) return {1'b1, r[6], 6'(c < 32 ? c : c + 28)};
        return {1'b0, r[6:5], 1'b0, r[3:0]};
    endfunction
    // Mute forces the muted code while the stored code is kept
    function automatic logic [7:0] exp_out(logic [6:0] m, logic [5:0] v);
        return m[1] ? 8'h00 : {2'h0, v};
    endfunction
    task automatic check_outs();
        chk("amp_enable", {7'h00, mode_e[0]}, {7'h00, amp_enable});
        chk("mute", {7'h00, mode_e[1]}, {7'h00, mute});
        chk("test_sel", 8'h00, {7'h00, factory_test_select});
        chk("gain_code", {2'h0, vol_e}, {2'h0, gain_code});
        chk("gain_out", exp_out(mode_e, vol_e), {2'h0, gain_out});
    endtask
    task automatic xact(input logic [7:0] a, input int n, input bit ok);
        logic [7:0] d;
        logic       k_ack;
        i_master.start_cond();
        i_master.put_byte(a, k_ack);
        chk("addr_ack", {7'h00, ok}, {7'h00, k_ack});
        for (int k = 0; k < n; k++) begin
            d = rand_byte();
            i_master.put_byte(d, k_ack);
            chk("data_ack", {7'h00, ok}, {7'h00, k_ack});
            if (ok && d[7]) vol_e = d[5:0];
            if (ok && !d[7]) mode_e = d[6:0];
        end
        i_master.stop_cond();
        check_outs();
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial begin
        // About twice the longest expected run
        #300000;
        fails++;
        tally_and_finish();
    end
    initial begin
        rst_b = 1'b0;
        clk_en = 1'b1;
        mode_e = 7'h00;
        vol_e = 6'h00;
        seed_ret = $urandom(40717);
        repeat (6) @(negedge mclk);
        rst_b = 1'b1;
        @(negedge mclk);
        check_outs();
        $display("test reset_defaults done");
        for (int t = 0; t < 40; t++) begin
            i_master.phase = 2 + ($urandom % 4);
            xact(8'hde, 1 + ($urandom % 3), 1'b1);
        end
        $display("test random_writes done");
        // Frozen slave must neither answer nor store
        clk_en = 1'b0;
        xact(8'hde, 1, 1'b0);
        clk_en = 1'b1;
        $display("test clock_freeze done");
        xact(8'hdc, 2, 1'b0);
        xact(8'hdf, 2, 1'b0);
        xact(8'hde, 1, 1'b1);
        i_master.scl = 1'b0;
        i_master.put_byte({2'b10, (vol_e == 6'h05) ? 6'h06 : 6'h05}, ack);
        chk("stray_ack", 8'h00, {7'h00, ack});
        check_outs();
        $display("test refused_traffic done");
        i_master.start_cond();
        i_master.put_byte(8'hde, ack);
        chk("mid_addr_ack", 8'h01, {7'h00, ack});
        i_master.put_byte(8'h01, ack);
        chk("mid_data_ack", 8'h01, {7'h00, ack});
        chk("enable_set", 8'h01, {7'h00, amp_enable});
        rst_b = 1'b0;
        i_master.put_byte(8'hbf, ack);
        chk("reset_ack", 8'h00, {7'h00, ack});
        rst_b = 1'b1;
        mode_e = 7'h00;
        vol_e = 6'h00;
        i_master.stop_cond();
        check_outs();
        xact(8'hde, 1, 1'b1);
        $display("test mid_reset done");
        tally_and_finish();
    end
endmodule // tb_top
